// [src/tocu_map.svh]
/*
 * Constants of the timer output compare unit: waveform mode codes, compare
 * action codes, reset values and counter limits.
 * Assumes inclusion by bare name from the package; the design module uses the macros without including it.
 */
`ifndef TOCU_MAP_SVH
`define TOCU_MAP_SVH

`define TOCU_WGM_NORMAL 4'h0
`define TOCU_WGM_CTC_A 4'h4
`define TOCU_WGM_FAST_8 4'h5
`define TOCU_WGM_FAST_9 4'h6
`define TOCU_WGM_FAST_10 4'h7
`define TOCU_WGM_CTC_CAP 4'hc
`define TOCU_WGM_RSVD 4'hd
`define TOCU_WGM_FAST_CAP 4'he
`define TOCU_WGM_FAST_A 4'hf
`define TOCU_TOP_8 16'h00ff
`define TOCU_TOP_9 16'h01ff
`define TOCU_TOP_10 16'h03ff
`define TOCU_MAX 16'hffff
`define TOCU_ZERO 16'h0000
`define TOCU_ACT_NONE 2'h0
`define TOCU_ACT_TOGGLE 2'h1
`define TOCU_ACT_CLEAR 2'h2
`define TOCU_ACT_SET 2'h3
`define TOCU_RST_WORD 16'h0000
`define TOCU_RST_BYTE 8'h00

`endif

// [src/tocu_pkg.sv]
/*
 * Types of the timer output compare unit.
 * Assumes tocu_map.svh is on the include path.
 */
`default_nettype none
package tocu_pkg;
	`include "tocu_map.svh"

	// Byte-wide register access of one compare channel.
	typedef struct packed {
		logic wr_high;
		logic wr_low;
		logic [7:0] data;
	} tocu_bus_s;

	// Decoded facts about the current waveform mode.
	typedef struct packed {
		logic pwm;
		logic top_is_a;
		logic top_is_cap;
		logic clear_at_top;
	} tocu_mode_s;

	typedef enum logic [2:0] {
		TOCU_CNT_IDLE = 3'b001,
		TOCU_CNT_RUN = 3'b010,
		TOCU_CNT_HOLD = 3'b100
	} tocu_cnt_e;
endpackage
`default_nettype wire

// [src/tocu_top.sv]
/*
 * Three output compare channels of a 16-bit timer with its counter.
 * Assumes byte strobes and the timer tick come from logic on clk_sys_in.
 */
`default_nettype none
module tocu_top
	import tocu_pkg::*;
#(
	parameter int CHANNELS = 3
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// Timer tick and mode
	input wire logic timer_tick_in,
	input wire logic [3:0] waveform_gen_select_in,
	input wire logic [15:0] capture_value_reg_in,
	// Counter write access
	input wire logic counter_wr_high_in,
	input wire logic counter_wr_low_in,
	input wire logic [7:0] counter_wr_data_in,
	// Per-channel compare access and control
	input wire tocu_bus_s [CHANNELS-1:0] compare_bus_in,
	input wire logic [CHANNELS-1:0] compare_irq_enable_in,
	input wire logic [CHANNELS-1:0] flag_clear_in,
	input wire logic [CHANNELS-1:0] irq_ack_in,
	input wire logic [CHANNELS-1:0] force_match_strobe_in,
	input wire logic [CHANNELS-1:0][1:0] compare_output_action_in,
	input wire logic [CHANNELS-1:0] port_value_in,
	input wire logic [CHANNELS-1:0] pin_direction_bit_in,
	// Counter and compare state
	output logic [15:0] counter_value_out,
	output logic [CHANNELS-1:0][15:0] compare_value_reg_out,
	output logic [CHANNELS-1:0][7:0] compare_value_high_out,
	output logic [CHANNELS-1:0][7:0] compare_value_low_out,
	output logic [CHANNELS-1:0] compare_match_flag_out,
	output logic [CHANNELS-1:0] irq_out,
	// Waveform outputs and pins
	output logic [CHANNELS-1:0] waveform_output_bit_out,
	output logic [CHANNELS-1:0] pin_out,
	output logic [CHANNELS-1:0] pin_oe_out
);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------

	function automatic tocu_mode_s decode_mode(input logic [3:0] wgm);
		tocu_mode_s m;
		m.pwm = !(wgm == `TOCU_WGM_NORMAL || wgm == `TOCU_WGM_CTC_A || wgm == `TOCU_WGM_CTC_CAP
			|| wgm == `TOCU_WGM_RSVD);
		m.top_is_a = (wgm == `TOCU_WGM_CTC_A) || (wgm == 4'h9) || (wgm == 4'hb) || (wgm == `TOCU_WGM_FAST_A);
		m.top_is_cap = (wgm == `TOCU_WGM_CTC_CAP) || (wgm == 4'h8) || (wgm == 4'ha) || (wgm == `TOCU_WGM_FAST_CAP);
		m.clear_at_top = (wgm == `TOCU_WGM_CTC_A) || (wgm == `TOCU_WGM_CTC_CAP) || (wgm == `TOCU_WGM_FAST_8)
			|| (wgm == `TOCU_WGM_FAST_9) || (wgm == `TOCU_WGM_FAST_10) || (wgm == `TOCU_WGM_FAST_CAP)
			|| (wgm == `TOCU_WGM_FAST_A);
		return m;
	endfunction

	// Action of one match on the output bit; zero keeps it.
	function automatic logic apply_action(input logic [1:0] act, input logic cur);
		case (act)
			`TOCU_ACT_TOGGLE: apply_action = !cur;
			`TOCU_ACT_CLEAR: apply_action = 1'b0;
			`TOCU_ACT_SET: apply_action = 1'b1;
			default: apply_action = cur;
		endcase
	endfunction

	tocu_mode_s mode;
	logic [15:0] top_value;
	logic at_top;
	logic at_zero;
	logic up;
	logic [7:0] stage_high;
	logic block_next;
	logic [CHANNELS-1:0][15:0] buffer_value;
	logic [CHANNELS-1:0] match;
	logic [CHANNELS-1:0] match_pend;
	logic counter_write;
	tocu_cnt_e cnt_state;

	assign mode = decode_mode(waveform_gen_select_in);
	assign counter_write = counter_wr_low_in;

	always_comb begin
		case (waveform_gen_select_in)
			`TOCU_WGM_FAST_8: top_value = `TOCU_TOP_8;
			`TOCU_WGM_FAST_9: top_value = `TOCU_TOP_9;
			`TOCU_WGM_FAST_10: top_value = `TOCU_TOP_10;
			default: begin
				if (mode.top_is_a) begin
					top_value = compare_value_reg_out[0];
				end else if (mode.top_is_cap) begin
					top_value = capture_value_reg_in;
				end else begin
					top_value = `TOCU_MAX;
				end
			end
		endcase
	end

	// A top match blocked by a counter write is lost, so the counter runs past it.
	assign at_top = mode.clear_at_top ? (counter_value_out == top_value) && !block_next : 1'b0;
	assign at_zero = (counter_value_out == `TOCU_ZERO);
	assign up = !(cnt_state == TOCU_CNT_HOLD);

	// ------------------------------------------------------------
	// Shared high-byte staging and counter
	// ------------------------------------------------------------

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage_high <= `TOCU_RST_BYTE;
		end else if (counter_wr_high_in) begin
			stage_high <= counter_wr_data_in;
		end else if (|{compare_bus_in[0].wr_high, compare_bus_in[CHANNELS-1].wr_high}) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (compare_bus_in[i].wr_high) begin
					stage_high <= compare_bus_in[i].data;
				end
			end
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (compare_bus_in[i].wr_high) begin
					stage_high <= compare_bus_in[i].data;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_state <= TOCU_CNT_IDLE;
		end else begin
			case (cnt_state)
				TOCU_CNT_IDLE: cnt_state <= timer_tick_in ? TOCU_CNT_RUN : TOCU_CNT_IDLE;
				TOCU_CNT_RUN: cnt_state <= TOCU_CNT_RUN;
				TOCU_CNT_HOLD: cnt_state <= TOCU_CNT_RUN;
				default: cnt_state <= TOCU_CNT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			counter_value_out <= `TOCU_RST_WORD;
		end else if (counter_write) begin
			counter_value_out <= {stage_high, counter_wr_data_in};
		end else if (timer_tick_in && up) begin
			if (at_top) begin
				counter_value_out <= `TOCU_ZERO;
			end else begin
				counter_value_out <= counter_value_out + 16'h0001;
			end
		end
	end

	// The block lasts until the next timer tick has been consumed.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			block_next <= 1'b0;
		end else if (counter_write) begin
			block_next <= 1'b1;
		end else if (timer_tick_in) begin
			block_next <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic [15:0] wr_word;
		assign wr_word = {stage_high, compare_bus_in[c].data};
		assign match[c] = (counter_value_out == compare_value_reg_out[c]);

		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				buffer_value[c] <= `TOCU_RST_WORD;
			end else if (compare_bus_in[c].wr_low && mode.pwm) begin
				buffer_value[c] <= wr_word;
			end
		end

		// Only CPU writes or buffer transfers change the compare value.
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				compare_value_reg_out[c] <= `TOCU_RST_WORD;
			end else if (compare_bus_in[c].wr_low && !mode.pwm) begin
				compare_value_reg_out[c] <= wr_word;
			end else if (mode.pwm && timer_tick_in && (at_top || at_zero)) begin
				compare_value_reg_out[c] <= buffer_value[c];
			end
		end

		always_comb begin
			compare_value_high_out[c] = mode.pwm ? buffer_value[c][15:8] : compare_value_reg_out[c][15:8];
			compare_value_low_out[c] = mode.pwm ? buffer_value[c][7:0] : compare_value_reg_out[c][7:0];
		end

		// Match seen on a tick; flag rises on the following tick.
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				match_pend[c] <= 1'b0;
			end else if (timer_tick_in) begin
				match_pend[c] <= match[c] && !block_next && !counter_write;
			end
		end

		// Setting wins over a clear in the same cycle.
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				compare_match_flag_out[c] <= 1'b0;
			end else if (timer_tick_in && match_pend[c]) begin
				compare_match_flag_out[c] <= 1'b1;
			end else if (flag_clear_in[c] || (irq_ack_in[c] && compare_irq_enable_in[c])) begin
				compare_match_flag_out[c] <= 1'b0;
			end
		end

		assign irq_out[c] = compare_match_flag_out[c] && compare_irq_enable_in[c];

		// Action bits are read live, so a change acts at the next match.
		always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				waveform_output_bit_out[c] <= 1'b0;
			end else if (!mode.pwm && force_match_strobe_in[c]) begin
				waveform_output_bit_out[c] <= apply_action(compare_output_action_in[c],
					waveform_output_bit_out[c]);
			end else if (timer_tick_in && match_pend[c]) begin
				if (mode.pwm) begin
					waveform_output_bit_out[c] <= (compare_output_action_in[c] == `TOCU_ACT_NONE) ?
						waveform_output_bit_out[c] : compare_output_action_in[c][0];
				end else begin
					waveform_output_bit_out[c] <= apply_action(compare_output_action_in[c],
						waveform_output_bit_out[c]);
				end
			end else if (mode.pwm && timer_tick_in && at_zero && compare_output_action_in[c][1]) begin
				waveform_output_bit_out[c] <= !compare_output_action_in[c][0];
			end
		end

		assign pin_out[c] = (compare_output_action_in[c] != `TOCU_ACT_NONE) ?
			waveform_output_bit_out[c] : port_value_in[c];
		assign pin_oe_out[c] = pin_direction_bit_in[c];
	end

endmodule // tocu_top
`default_nettype wire

// [dv/tocu_chk.sv]
/* Checker of tocu_top port relations, mostly on channel 0.
   Assumes a bind onto tocu_top with ports matched by name. */
`default_nettype none
module tocu_chk import tocu_pkg::*; #(parameter int CHANNELS = 3) (
	// Inputs
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic timer_tick_in,
	input wire logic [3:0] waveform_gen_select_in,
	input wire tocu_bus_s [CHANNELS-1:0] compare_bus_in,
	input wire logic [CHANNELS-1:0] compare_irq_enable_in,
	input wire logic [CHANNELS-1:0] flag_clear_in,
	input wire logic [CHANNELS-1:0] irq_ack_in,
	input wire logic [CHANNELS-1:0] force_match_strobe_in,
	input wire logic [CHANNELS-1:0][1:0] compare_output_action_in,
	input wire logic [CHANNELS-1:0] port_value_in,
	input wire logic [CHANNELS-1:0] pin_direction_bit_in,
	// Outputs
	input wire logic [CHANNELS-1:0][15:0] compare_value_reg_out,
	input wire logic [CHANNELS-1:0] compare_match_flag_out,
	input wire logic [CHANNELS-1:0] irq_out,
	input wire logic [CHANNELS-1:0] waveform_output_bit_out,
	input wire logic [CHANNELS-1:0] pin_out,
	input wire logic [CHANNELS-1:0] pin_oe_out
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);
	wire tk = timer_tick_in;
	wire m0 = waveform_gen_select_in == 4'h0;
	wire [1:0] a0 = compare_output_action_in[0];
	AST_IRQ: assert property (irq_out == (compare_match_flag_out & compare_irq_enable_in)) else $error("irq");
	AST_PIN: assert property (pin_out[0] == ((a0 != 2'h0) ? waveform_output_bit_out[0] : port_value_in[0])) else $error("pin");
	AST_OE: assert property (pin_oe_out == pin_direction_bit_in) else $error("oe");
	AST_FLAG_TICK: assert property (!tk && !compare_match_flag_out[0] |=> !compare_match_flag_out[0]) else $error("flag");
	AST_SW_CLEAR: assert property (flag_clear_in[2] && !tk |=> !compare_match_flag_out[2]) else $error("clear");
	AST_ACK: assert property (irq_ack_in[0] && compare_irq_enable_in[0] && !tk |=> !compare_match_flag_out[0]) else $error("ack");
	AST_LOW_WR: assert property (m0 && compare_bus_in[0].wr_low |=> compare_value_reg_out[0][7:0] == $past(compare_bus_in[0].data)) else $error("low");
	AST_HOLD: assert property (m0 && !compare_bus_in[0].wr_low |=> $stable(compare_value_reg_out[0])) else $error("hold");
	AST_FORCE: assert property (m0 && force_match_strobe_in[0] && a0 == 2'h1 && !tk |=> $changed(waveform_output_bit_out[0])) else $error("force");
	AST_RESET: assert property ($rose(rst_b_in) |-> waveform_output_bit_out == '0) else $error("reset");
	cover property ($rose(compare_match_flag_out[0]));
	cover property (m0 && force_match_strobe_in[0]);
	cover property (!m0 && compare_bus_in[1].wr_low);
endmodule // tocu_chk
`default_nettype wire

// [dv/tocu_bench.sv]
/* Scenario bench of tocu_top; each test task (t_match, t_force, t_pwm, t_ctc) drives the ports and judges them.
   Assumes tocu_pkg, tocu_top and tocu_chk are compiled first. */
`default_nettype none
module timer_output_compare_unit_bench import tocu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CHANNELS = 3;
	logic clk_sys_in, rst_b_in, timer_tick_in, counter_wr_high_in, counter_wr_low_in;
	logic [3:0] waveform_gen_select_in;
	logic [15:0] capture_value_reg_in, counter_value_out;
	logic [7:0] counter_wr_data_in;
	tocu_bus_s [2:0] compare_bus_in;
	logic [2:0] compare_irq_enable_in, flag_clear_in, irq_ack_in, force_match_strobe_in, port_value_in;
	logic [2:0] pin_direction_bit_in, compare_match_flag_out, irq_out, waveform_output_bit_out, pin_out, pin_oe_out;
	logic [2:0][1:0] compare_output_action_in;
	logic [2:0][15:0] compare_value_reg_out;
	logic [2:0][7:0] compare_value_high_out, compare_value_low_out;
	int error_cnt = 0;
	int checks = 0;
	tocu_top #(.CHANNELS(CHANNELS)) dut (.*);
	always #25 clk_sys_in = ~clk_sys_in;
	// ----
	// Tasks
	// ----
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			timer_tick_in <= 1'h1;
			@(posedge clk_sys_in);
			timer_tick_in <= 1'h0;
		end
		#1;
	endtask
	task automatic wr_cmp(input int c, input logic [15:0] v);
		@(posedge clk_sys_in);
		compare_bus_in[c] <= '{1'h1, 1'h0, v[15:8]};
		@(posedge clk_sys_in);
		compare_bus_in[c] <= '{1'h0, 1'h1, v[7:0]};
		@(posedge clk_sys_in);
		compare_bus_in[c] <= '0;
		#1;
	endtask
	task automatic wr_cnt(input logic [15:0] v);
		@(posedge clk_sys_in);
		counter_wr_high_in <= 1'h1;
		counter_wr_data_in <= v[15:8];
		@(posedge clk_sys_in);
		counter_wr_high_in <= 1'h0;
		counter_wr_low_in <= 1'h1;
		counter_wr_data_in <= v[7:0];
		@(posedge clk_sys_in);
		counter_wr_low_in <= 1'h0;
		#1;
	endtask
	// Bits are flag clear, interrupt service and force, two downto zero each.
	task automatic pulse(input logic [8:0] v);
		@(posedge clk_sys_in);
		{flag_clear_in, irq_ack_in, force_match_strobe_in} <= v;
		@(posedge clk_sys_in);
		{flag_clear_in, irq_ack_in, force_match_strobe_in} <= '0;
		#1;
	endtask
	task automatic t_match;
		@(posedge clk_sys_in);
		compare_output_action_in <= 6'h01;
		compare_irq_enable_in <= 3'h1;
		wr_cmp(0, 16'h1234);
		chk("cmp0", compare_value_reg_out[0], 16'h1234);
		chk("cmp0_hi", compare_value_high_out[0], 16'h0012);
		wr_cnt(16'h1231);
		tick(4);
		chk("flag_early", compare_match_flag_out, 16'h0);
		chk("cnt_run", counter_value_out, 16'h1235);
		tick(1);
		chk("flag", compare_match_flag_out, 16'h1);
		chk("irq", irq_out, 16'h1);
		chk("out_bit", waveform_output_bit_out, 16'h1);
		pulse(9'h008);
		chk("flag_ack", compare_match_flag_out, 16'h0);
		wr_cnt(16'h1234);
		tick(3);
		chk("flag_blk", compare_match_flag_out, 16'h0);
		wr_cmp(2, 16'h1238);
		tick(3);
		chk("flag2", compare_match_flag_out, 16'h4);
		chk("out_keep", waveform_output_bit_out, 16'h1);
		pulse(9'h020);
		chk("ack_off", compare_match_flag_out, 16'h4);
		pulse(9'h100);
		chk("flag_clr", compare_match_flag_out, 16'h0);
		$display("test match done");
	endtask
	task automatic t_force;
		logic e;
		logic [1:0] a;
		e = 1'h1;
		for (int i = 3; i >= 0; i--) begin
			a = 2'(i);
			e = (a == 2'h1) ? !e : (a == 2'h0) ? e : a[0];
			@(posedge clk_sys_in);
			compare_output_action_in[0] <= a;
			pulse(9'h001);
			chk("force_bit", waveform_output_bit_out, {2'h0, e});
			chk("force_flag", compare_match_flag_out, 16'h0);
			chk("pin", pin_out, {2'h3, (a != 2'h0) ? e : 1'h0});
			chk("pin_oe", pin_oe_out, 16'h5);
		end
		$display("test force done");
	endtask
	task automatic t_pwm;
		@(posedge clk_sys_in);
		waveform_gen_select_in <= 4'h5;
		compare_output_action_in <= 6'h04;
		wr_cmp(1, 16'h0040);
		chk("mode_keep", waveform_output_bit_out, 16'h1);
		chk("cmp1", compare_value_reg_out[1], 16'h0);
		chk("buf1", compare_value_low_out[1], 16'h40);
		pulse(9'h002);
		chk("force_pwm", waveform_output_bit_out, 16'h1);
		wr_cnt(16'h00fe);
		tick(3);
		chk("cmp1_load", compare_value_reg_out[1], 16'h0040);
		$display("test pwm done");
	endtask
	task automatic t_ctc;
		@(posedge clk_sys_in);
		waveform_gen_select_in <= 4'h4;
		wr_cmp(0, 16'h0003);
		wr_cnt(16'h0002);
		tick(2);
		chk("ctc_wrap", counter_value_out, 16'h0000);
		@(posedge clk_sys_in);
		rst_b_in <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		rst_b_in <= 1'h1;
		@(posedge clk_sys_in);
		#1;
		chk("rst_mid_bit", waveform_output_bit_out, 16'h0);
		chk("rst_mid_cnt", counter_value_out, 16'h0);
		$display("test ctc done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		{clk_sys_in, rst_b_in, timer_tick_in, counter_wr_high_in, counter_wr_low_in, counter_wr_data_in} = '0;
		{waveform_gen_select_in, capture_value_reg_in, compare_bus_in, compare_irq_enable_in} = '0;
		{flag_clear_in, irq_ack_in, force_match_strobe_in, compare_output_action_in} = '0;
		port_value_in = 3'h6;
		pin_direction_bit_in = 3'h5;
		repeat (20) @(posedge clk_sys_in);
		rst_b_in <= 1'h1;
		@(posedge clk_sys_in);
		#1;
		chk("rst_bit", waveform_output_bit_out, 16'h0);
		$display("test reset done");
		t_match;
		t_force;
		t_pwm;
		t_ctc;
		tally_and_finish;
	end
endmodule // timer_output_compare_unit_bench
bind tocu_top tocu_chk #(.CHANNELS(CHANNELS)) chk_i (.*);
`default_nettype wire
